// [verilog/stl_pkg.sv]
// shared constants and types for the self-test results log
package stl_pkg;

  // ----------------------------------------------------------------
  // log geometry
  // ----------------------------------------------------------------
  localparam int STL_DEPTH = 20;
  localparam int STL_IDX_W = 5;

  // ----------------------------------------------------------------
  // function codes and outcome codes
  // ----------------------------------------------------------------
  localparam logic [2:0] STL_FC_SHORT = 3'h1;
  localparam logic [2:0] STL_FC_EXTENDED = 3'h2;
  localparam logic [2:0] STL_FC_ABORT_DEF = 3'h4;
  localparam logic [3:0] STL_RES_PASS = 4'h0;
  localparam logic [3:0] STL_RES_ABORT_APP = 4'h1;
  localparam logic [3:0] STL_RES_ABORT_RST = 4'h2;
  localparam logic [3:0] STL_RES_IN_PROG = 4'hf;

  // ----------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] STL_OFS_CTRL = 8'h00;
  localparam logic [7:0] STL_OFS_STATUS = 8'h04;
  localparam logic [7:0] STL_OFS_INT_STAT = 8'h08;
  localparam logic [7:0] STL_OFS_INT_MASK = 8'h0c;
  localparam logic [7:0] STL_OFS_LOG_IDX = 8'h10;
  localparam logic [7:0] STL_OFS_LOG_W0 = 8'h14;
  localparam logic [7:0] STL_OFS_LOG_W1 = 8'h18;
  localparam logic [7:0] STL_OFS_LOG_W2 = 8'h1c;
  localparam int STL_CTRL_EN_BIT = 0;
  localparam logic STL_CTRL_EN_RST = 1'b1;
  localparam int STL_INT_W = 4;
  localparam int STL_INT_START = 0;
  localparam int STL_INT_PASS = 1;
  localparam int STL_INT_FAIL = 2;
  localparam int STL_INT_ABORT = 3;
  localparam logic [STL_INT_W-1:0] STL_INT_MASK_RST = 4'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] res;
    logic [3:0] skey;
    logic [7:0] asc;
    logic [7:0] ascq;
    logic [7:0] fru;
    logic lba_vld;
    logic [31:0] lba;
  } stl_outcome_s;

  typedef struct packed {
    logic vld;
    logic [2:0] fc;
    stl_outcome_s out;
  } stl_entry_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } stl_apb_req_s;

  typedef enum logic [3:0] {
    STL_ST_IDLE = 4'h1,
    STL_ST_SAVE_NEW = 4'h2,
    STL_ST_RUN = 4'h4,
    STL_ST_SAVE_END = 4'h8
  } stl_state_e;

endpackage

// [verilog/stl_log_array.sv]
// twenty-deep newest-first array of self-test parameter blocks
`timescale 1ns/1ps
module stl_log_array import stl_pkg::*; #(
  parameter int DEPTH = STL_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // insert a fresh block at the head
  input wire logic ins,
  input wire logic [2:0] ins_fc,
  // rewrite the head block's outcome
  input wire logic upd,
  input wire stl_outcome_s upd_out,
  // read side
  input wire logic [STL_IDX_W-1:0] rd_idx,
  output stl_entry_s rd_entry,
  output logic [STL_IDX_W-1:0] count
);

  stl_entry_s mem_q [DEPTH];
  logic [STL_IDX_W-1:0] count_q;
  stl_entry_s new_entry;
  logic rd_hit;

  // ----------------------------------------------------------------
  // new head block
  // ----------------------------------------------------------------
  always_comb begin
    new_entry = '0;
    new_entry.vld = 1'b1;
    new_entry.fc = ins_fc;
    new_entry.out.res = STL_RES_IN_PROG;
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // the last slot simply falls off the end when a new block comes in
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (ins) begin
      mem_q[0] <= new_entry;
      for (int i = 1; i < DEPTH; i++) begin
        mem_q[i] <= mem_q[i-1];
      end
    end else if (upd) begin
      mem_q[0].out <= upd_out;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= '0;
    end else if (ins && int'(count_q) < DEPTH) begin
      count_q <= count_q + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  assign rd_hit = int'(rd_idx) < DEPTH;
  assign rd_entry = rd_hit ? mem_q[rd_idx] : '0;
  assign count = count_q;

endmodule

// [verilog/stl_self_test_log.sv]
// self-test sequencing, results log control and apb register slave
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps

module stl_self_test_log import stl_pkg::*; #(
  parameter logic [2:0] ABORT_FC = STL_FC_ABORT_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire stl_apb_req_s apb_req,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // diagnostic command from the interface front end
  input wire logic diag_valid,
  input wire logic [2:0] diag_fc,
  input wire logic bus_reset,
  input wire logic bus_dev_reset,
  // test engine
  output logic test_go,
  output logic [2:0] test_fc,
  output logic test_stop,
  input wire logic test_done,
  input wire stl_outcome_s test_result,
  // non-volatile store
  output logic nv_save_req,
  input wire logic nv_save_ack,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  stl_state_e state_q, state_d;
  logic ctrl_en_q;
  logic [STL_INT_W-1:0] int_stat_q, int_mask_q, int_ev;
  logic [STL_IDX_W-1:0] log_idx_q;
  logic [31:0] prdata_q;
  logic test_go_q, test_stop_q, ack_gap_q;
  logic [2:0] test_fc_q;
  logic pend_q, pend_d;
  logic [3:0] pend_res_q, pend_res_d;
  logic st_idle, st_save_new, st_run, st_save_end;
  logic fc_test, start_ok, abort_fc, abort_rst, abort_any;
  logic [3:0] abort_res;
  logic ins, upd, go_d, stop_d;
  stl_outcome_s upd_out;
  stl_entry_s rd_entry;
  logic [STL_IDX_W-1:0] log_count;
  logic wr_en, rd_setup, addr_hit;
  logic wr_ctrl, wr_int_stat, wr_int_mask, wr_log_idx;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  assign st_idle = state_q == STL_ST_IDLE;
  assign st_save_new = state_q == STL_ST_SAVE_NEW;
  assign st_run = state_q == STL_ST_RUN;
  assign st_save_end = state_q == STL_ST_SAVE_END;
  assign fc_test = diag_fc == STL_FC_SHORT
                || diag_fc == STL_FC_EXTENDED;
  assign start_ok = st_idle && diag_valid && ctrl_en_q && fc_test;
  // the abort code only counts with a valid command strobe
  assign abort_fc = diag_valid && diag_fc == ABORT_FC;
  assign abort_rst = bus_reset || bus_dev_reset;
  // a function-code abort takes priority when both arrive together
  assign abort_res = abort_fc ? STL_RES_ABORT_APP
                              : STL_RES_ABORT_RST;
  assign abort_any = abort_fc || abort_rst;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // idle -> save_new on an accepted start, with the new block pushed;
  // save_new -> run once the in-progress copy is stored, or -> save_end if an abort is held;
  // run -> save_end on done or abort, with the outcome rewritten;
  // save_end -> idle once the outcome copy is stored;
  // the test engine never runs ahead of a stored in-progress block
  always_comb begin
    state_d = state_q;
    ins = 1'b0;
    upd = 1'b0;
    go_d = 1'b0;
    stop_d = 1'b0;
    pend_d = pend_q;
    pend_res_d = pend_res_q;
    upd_out = '0;
    int_ev = '0;
    unique case (state_q)
      STL_ST_IDLE: begin
        if (start_ok) begin
          ins = 1'b1;
          pend_d = 1'b0;
          int_ev[STL_INT_START] = 1'b1;
          state_d = STL_ST_SAVE_NEW;
        end
      end
      STL_ST_SAVE_NEW: begin
        // an abort while the head block is being saved is held back
        // so the in-progress copy still lands before the abort code
        if (abort_any && !pend_q) begin
          pend_d = 1'b1;
          pend_res_d = abort_res;
        end
        if (nv_save_ack) begin
          if (pend_d) begin
            upd = 1'b1;
            upd_out.res = pend_res_d;
            int_ev[STL_INT_ABORT] = 1'b1;
            state_d = STL_ST_SAVE_END;
          end else begin
            go_d = 1'b1;
            state_d = STL_ST_RUN;
          end
        end
      end
      STL_ST_RUN: begin
        if (abort_any) begin
          stop_d = 1'b1;
          upd = 1'b1;
          upd_out.res = abort_res;
          int_ev[STL_INT_ABORT] = 1'b1;
          state_d = STL_ST_SAVE_END;
        end else if (test_done) begin
          upd = 1'b1;
          if (test_result.res == STL_RES_PASS) begin
            upd_out.res = STL_RES_PASS;
            int_ev[STL_INT_PASS] = 1'b1;
          end else begin
            // sense data and lba are only kept for a failure
            upd_out = test_result;
            int_ev[STL_INT_FAIL] = 1'b1;
          end
          state_d = STL_ST_SAVE_END;
        end
      end
      STL_ST_SAVE_END: begin
        if (nv_save_ack) begin
          state_d = STL_ST_IDLE;
        end
      end
      default: begin
        state_d = STL_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= STL_ST_IDLE;
      pend_q <= 1'b0;
      pend_res_q <= STL_RES_PASS;
      test_go_q <= 1'b0;
      test_stop_q <= 1'b0;
      test_fc_q <= 3'h0;
      ack_gap_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pend_q <= pend_d;
      pend_res_q <= pend_res_d;
      test_go_q <= go_d;
      test_stop_q <= stop_d;
      ack_gap_q <= nv_save_ack;
      if (ins) begin
        test_fc_q <= diag_fc;
      end
    end
  end

  // one save per request: the request drops for a cycle after each ack
  assign nv_save_req = (st_save_new || st_save_end) && !ack_gap_q;
  assign test_go = test_go_q;
  assign test_stop = test_stop_q;
  assign test_fc = test_fc_q;

  // ----------------------------------------------------------------
  // results log
  // ----------------------------------------------------------------
  stl_log_array #(
    .DEPTH(STL_DEPTH)
  ) u_log (
    .clk(clk),
    .rst_b(rst_b),
    .ins(ins),
    // the code comes straight from the command on the start edge
    .ins_fc(diag_fc),
    .upd(upd),
    .upd_out(upd_out),
    .rd_idx(log_idx_q),
    .rd_entry(rd_entry),
    .count(log_count)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // register map, one aligned word each
  //   ctrl: bit 0 lets new tests start
  //   status: [3:0] one-hot state, [8:4] blocks held
  //   int_stat: start, pass, fail, abort; write one to clear
  //   int_mask: same layout; irq follows the unmasked bits
  //   log_idx: block to show, 0 is the newest, 20 and up read zero
  //   log_w0: fc [2:0], outcome [7:4], sense key [11:8], asc, ascq
  //   log_w1: failing lba
  //   log_w2: block valid, lba valid, fru [15:8]
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_setup = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  assign addr_hit = apb_req.paddr[7:5] == 3'h0
                 && apb_req.paddr[1:0] == 2'h0;

  // ----------------------------------------------------------------
  // write strobes
  // ----------------------------------------------------------------
  // one strobe per writable register keeps the register process short
  assign wr_ctrl = wr_en && apb_req.paddr == STL_OFS_CTRL;
  assign wr_int_stat = wr_en && apb_req.paddr == STL_OFS_INT_STAT;
  assign wr_int_mask = wr_en && apb_req.paddr == STL_OFS_INT_MASK;
  assign wr_log_idx = wr_en && apb_req.paddr == STL_OFS_LOG_IDX;

  always_comb begin
    rd_word = 32'h0;
    unique case (apb_req.paddr)
      STL_OFS_CTRL: rd_word[STL_CTRL_EN_BIT] = ctrl_en_q;
      STL_OFS_STATUS: rd_word = {23'h0, log_count, state_q};
      STL_OFS_INT_STAT: rd_word = {28'h0, int_stat_q};
      STL_OFS_INT_MASK: rd_word = {28'h0, int_mask_q};
      STL_OFS_LOG_IDX: rd_word = {27'h0, log_idx_q};
      STL_OFS_LOG_W0: rd_word = {4'h0, rd_entry.out.ascq,
                                 rd_entry.out.asc, rd_entry.out.skey,
                                 rd_entry.out.res, 1'b0,
                                 rd_entry.fc};
      STL_OFS_LOG_W1: rd_word = rd_entry.out.lba;
      STL_OFS_LOG_W2: rd_word = {16'h0, rd_entry.out.fru, 6'h0,
                                 rd_entry.out.lba_vld,
                                 rd_entry.vld};
      default: rd_word = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_en_q <= STL_CTRL_EN_RST;
      int_mask_q <= STL_INT_MASK_RST;
      log_idx_q <= '0;
      prdata_q <= 32'h0;
    end else begin
      // clearing the enable only blocks new starts; a running test goes on
      if (wr_ctrl) begin
        ctrl_en_q <= apb_req.pwdata[STL_CTRL_EN_BIT];
      end
      if (wr_int_mask) begin
        int_mask_q <= apb_req.pwdata[STL_INT_W-1:0];
      end
      if (wr_log_idx) begin
        log_idx_q <= apb_req.pwdata[STL_IDX_W-1:0];
      end
      // read data is caught at setup, so the access phase shows a flop
      if (rd_setup) begin
        prdata_q <= rd_word;
      end
    end
  end

  // write-one-to-clear; a new event in the same cycle wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int_stat_q <= '0;
    end else if (wr_int_stat) begin
      int_stat_q <= (int_stat_q & ~apb_req.pwdata[STL_INT_W-1:0]) | int_ev;
    end else begin
      int_stat_q <= int_stat_q | int_ev;
    end
  end

  assign irq = |(int_stat_q & int_mask_q);
  // no wait states: every word comes from a flop or a small decode
  assign pready = 1'b1;
  assign pslverr = apb_req.psel && apb_req.penable && !addr_hit;
  assign prdata = prdata_q;

endmodule

// [sim/stl_self_test_log_props.sv]
// concurrent checks on the ports of the self-test results log
`timescale 1ns/1ps
module stl_self_test_log_props import stl_pkg::*; #(
  parameter logic [2:0] ABORT_FC = STL_FC_ABORT_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb
  input wire stl_apb_req_s apb_req,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // command side
  input wire logic diag_valid,
  input wire logic [2:0] diag_fc,
  input wire logic bus_reset,
  input wire logic bus_dev_reset,
  // test engine and store
  input wire logic test_go,
  input wire logic [2:0] test_fc,
  input wire logic test_stop,
  input wire logic test_done,
  input wire stl_outcome_s test_result,
  input wire logic nv_save_req,
  input wire logic nv_save_ack,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // run tracking
  // ----------------------------------------------------------------
  // lags the design's run state by a cycle, so early aborts go unchecked
  logic run_q;
  logic run_d;
  logic bad_addr;
  logic acc;
  assign run_d = test_go | (run_q & ~test_stop & ~test_done);
  assign acc = apb_req.psel & apb_req.penable;
  assign bad_addr = (apb_req.paddr[7:5] != 3'h0)
                  | (apb_req.paddr[1:0] != 2'h0);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run_d;
    end
  end
  sequence fc_abort_s;
    run_q && !test_stop && diag_valid && diag_fc == ABORT_FC;
  endsequence
  sequence rst_abort_s;
    run_q && !test_stop && (bus_reset || bus_dev_reset);
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  apb_resp_a: assert property (acc |-> pready && pslverr == bad_addr)
    else $error("apb response wrong");
  apb_errdata_a: assert property (
    acc && !apb_req.pwrite && bad_addr |-> prdata == 32'h0)
    else $error("unmapped read returned data");
  save_hold_a: assert property (
    nv_save_req && !nv_save_ack |=> nv_save_req)
    else $error("save request dropped before ack");
  save_drop_a: assert property (
    nv_save_req && nv_save_ack |=> !nv_save_req)
    else $error("save request held after ack");
  go_after_save_a: assert property (
    test_go |-> $past(nv_save_ack) && !nv_save_req)
    else $error("test started without a completed save");
  go_code_a: assert property (
    test_go |-> test_fc == STL_FC_SHORT || test_fc == STL_FC_EXTENDED)
    else $error("test started with a bad function code");
  fc_stop_a: assert property (fc_abort_s |=> test_stop)
    else $error("function code abort did not stop the test");
  reset_stop_a: assert property (rst_abort_s |=> test_stop)
    else $error("reset abort did not stop the test");
  stop_save_a: assert property (
    test_stop |-> ##[0:2] nv_save_req ##1 !test_stop)
    else $error("abort not saved");
  done_save_a: assert property (
    test_done && run_q |-> ##[1:3] nv_save_req)
    else $error("finished test not saved");
endmodule

// [sim/stl_far_model.sv]
// far-side model: non-volatile store and test engine
`timescale 1ns/1ps
module stl_far_model import stl_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pacing and outcome chosen by the bench
  input wire logic [7:0] ack_dly,
  input wire logic [7:0] run_dly,
  input wire stl_outcome_s res_cfg,
  // save handshake
  input wire logic nv_save_req,
  output logic nv_save_ack,
  // test engine
  input wire logic test_go,
  input wire logic test_stop,
  output logic test_done,
  output stl_outcome_s test_result
);
  logic [7:0] ack_cnt_q;
  logic [7:0] run_cnt_q;
  logic run_q;
  // outcome only means something with done, so show junk otherwise
  assign test_result = test_done ? res_cfg : ~res_cfg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_cnt_q <= 8'h00;
      run_cnt_q <= 8'h00;
      run_q <= 1'b0;
      nv_save_ack <= 1'b0;
      test_done <= 1'b0;
    end else begin
      nv_save_ack <= nv_save_req && !nv_save_ack && ack_cnt_q >= ack_dly;
      ack_cnt_q <= (nv_save_req && !nv_save_ack) ? ack_cnt_q + 8'h01 : 8'h00;
      test_done <= run_q && !test_stop && !test_done && run_cnt_q == run_dly;
      run_cnt_q <= run_q ? run_cnt_q + 8'h01 : 8'h00;
      run_q <= test_go || (run_q && !test_stop && !test_done);
    end
  end
endmodule

// [sim/stl_self_test_log_tb_top.sv]
// self-checking bench for the self-test results log
`timescale 1ns/1ps
module stl_self_test_log_tb_top import stl_pkg::*;;
  localparam stl_outcome_s FAIL_R =
    '{4'h3, 4'h4, 8'h11, 8'h22, 8'h5a, 1'b1, 32'h12345};
  localparam stl_outcome_s PASS_R =
    '{4'h0, 4'h4, 8'h11, 8'h22, 8'h5a, 1'b1, 32'h12345};
  logic clk, rst_b, pready, pslverr, irq, err;
  stl_apb_req_s apb_req;
  logic [31:0] prdata, rd;
  logic diag_valid, bus_reset, bus_dev_reset, test_go, test_stop, test_done;
  logic nv_save_req, nv_save_ack;
  logic [2:0] diag_fc, test_fc;
  stl_outcome_s test_result, res_cfg;
  logic [7:0] ack_dly, run_dly;
  logic [7:0] exp_q[$];
  int error_cnt, checks;
  stl_self_test_log #(.ABORT_FC(STL_FC_ABORT_DEF)) DUT (
    .clk(clk), .rst_b(rst_b),
    .apb_req(apb_req), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .diag_valid(diag_valid), .diag_fc(diag_fc), .bus_reset(bus_reset),
    .bus_dev_reset(bus_dev_reset), .test_go(test_go), .test_fc(test_fc),
    .test_stop(test_stop), .test_done(test_done), .test_result(test_result),
    .nv_save_req(nv_save_req), .nv_save_ack(nv_save_ack), .irq(irq));
  stl_far_model u_far (.clk(clk), .rst_b(rst_b), .ack_dly(ack_dly),
    .run_dly(run_dly), .res_cfg(res_cfg), .nv_save_req(nv_save_req),
    .nv_save_ack(nv_save_ack), .test_go(test_go), .test_stop(test_stop),
    .test_done(test_done), .test_result(test_result));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  // one idle edge after each transfer keeps psel from being driven twice
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= a;
    apb_req.pwdata <= d;
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task automatic rd_w(input logic [4:0] idx, input logic [7:0] a);
    apb(1'b1, STL_OFS_LOG_IDX, {27'h0, idx});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic pulse(input logic [1:0] k, input logic [2:0] fc);
    diag_valid <= (k == 2'd0);
    diag_fc <= fc;
    bus_reset <= (k == 2'd1);
    bus_dev_reset <= (k == 2'd2);
    @(posedge clk);
    diag_valid <= 1'b0;
    bus_reset <= 1'b0;
    bus_dev_reset <= 1'b0;
  endtask
  task automatic wait_state(input logic [3:0] st);
    int n;
    n = 0;
    do begin
      apb(1'b0, STL_OFS_STATUS, 32'h0);
      n++;
    end while (rd[3:0] !== st && n < 500);
    chk("state", {28'h0, rd[3:0]}, {28'h0, st});
  endtask
  // expected head byte of word 0 is kept newest first, oldest dropped
  task automatic logged(input logic [2:0] fc, input logic [3:0] res);
    wait_state(4'h1);
    exp_q.push_front({res, 1'b0, fc});
    if (exp_q.size() > STL_DEPTH) void'(exp_q.pop_back());
    rd_w(5'd0, STL_OFS_LOG_W0);
    chk("head", {24'h0, rd[7:0]}, {24'h0, exp_q[0]});
  endtask
  function automatic logic [31:0] idle_st();
    return {23'h0, 5'(exp_q.size()), 4'h1};
  endfunction
  task automatic give_verdict();
    $display("checks %0d, error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    rst_b = 1'b0;
    apb_req = '0;
    {diag_valid, bus_reset, bus_dev_reset, diag_fc} = '0;
    res_cfg = PASS_R;
    ack_dly = 8'h00;
    run_dly = 8'h04;
    error_cnt = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdc("ctrl", STL_OFS_CTRL, 32'h1);
    rdc("status", STL_OFS_STATUS, 32'h1);
    rdc("mask", STL_OFS_INT_MASK, 32'h0);
    apb(1'b0, 8'h22, 32'h0);
    chk("unmapped", {rd[31:1], err}, 32'h1);
    apb(1'b1, STL_OFS_INT_MASK, 32'hf);
    pulse(2'd0, STL_FC_SHORT);
    logged(STL_FC_SHORT, STL_RES_PASS);
    chk("pass_w0", rd, 32'h00000001);
    rd_w(5'd0, STL_OFS_LOG_W1);
    chk("pass_lba", rd, 32'h0);
    chk("irq_set", {31'h0, irq}, 32'h1);
    rdc("int_stat", STL_OFS_INT_STAT, 32'h3);
    apb(1'b1, STL_OFS_INT_STAT, 32'hf);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    res_cfg <= FAIL_R;
    ack_dly <= 8'h09;
    pulse(2'd0, STL_FC_EXTENDED);
    logged(STL_FC_EXTENDED, 4'h3);
    chk("fail_w0", rd, 32'h02211432);
    chk("test_fc", {29'h0, test_fc}, {29'h0, STL_FC_EXTENDED});
    rd_w(5'd0, STL_OFS_LOG_W1);
    chk("fail_lba", rd, 32'h12345);
    rd_w(5'd0, STL_OFS_LOG_W2);
    chk("fail_w2", rd, 32'h00005a03);
    run_dly <= 8'hc8;
    for (int k = 0; k < 3; k++) begin
      pulse(2'd0, STL_FC_SHORT);
      wait_state(4'h4);
      rd_w(5'd0, STL_OFS_LOG_W0);
      chk("in_prog", {28'h0, rd[7:4]}, {28'h0, STL_RES_IN_PROG});
      pulse(2'(k), STL_FC_ABORT_DEF);
      logged(STL_FC_SHORT,
             k == 0 ? STL_RES_ABORT_APP : STL_RES_ABORT_RST);
    end
    ack_dly <= 8'h14;
    pulse(2'd0, STL_FC_EXTENDED);
    repeat (3) @(posedge clk);
    pulse(2'd1, STL_FC_EXTENDED);
    logged(STL_FC_EXTENDED, STL_RES_ABORT_RST);
    apb(1'b1, STL_OFS_CTRL, 32'h0);
    pulse(2'd0, STL_FC_SHORT);
    rdc("dis_start", STL_OFS_STATUS, idle_st());
    apb(1'b1, STL_OFS_CTRL, 32'h1);
    pulse(2'd0, 3'h0);
    rdc("bad_fc", STL_OFS_STATUS, idle_st());
    {ack_dly, run_dly} <= 16'h0002;
    res_cfg <= PASS_R;
    for (int i = 0; i < 18; i++) begin
      pulse(2'd0, i[0] ? STL_FC_EXTENDED : STL_FC_SHORT);
      logged(i[0] ? STL_FC_EXTENDED : STL_FC_SHORT, STL_RES_PASS);
    end
    rdc("full", STL_OFS_STATUS, 32'h141);
    for (int i = 0; i < STL_DEPTH; i++) begin
      rd_w(5'(i), STL_OFS_LOG_W0);
      chk("order", {24'h0, rd[7:0]}, {24'h0, exp_q[i]});
    end
    rd_w(5'd20, STL_OFS_LOG_W2);
    chk("beyond", rd, 32'h0);
    apb(1'b1, STL_OFS_INT_MASK, 32'h0);
    chk("irq_mask", {31'h0, irq}, 32'h0);
    apb(1'b1, STL_OFS_INT_MASK, 32'h2);
    chk("irq_unmask", {31'h0, irq}, 32'h1);
    give_verdict();
  end
endmodule
bind stl_self_test_log stl_self_test_log_props #(.ABORT_FC(ABORT_FC)) u_props (
  .clk(clk), .rst_b(rst_b), .apb_req(apb_req), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .diag_valid(diag_valid),
  .diag_fc(diag_fc), .bus_reset(bus_reset), .bus_dev_reset(bus_dev_reset),
  .test_go(test_go), .test_fc(test_fc), .test_stop(test_stop),
  .test_done(test_done), .test_result(test_result),
  .nv_save_req(nv_save_req), .nv_save_ack(nv_save_ack), .irq(irq));
